// ### core/dss_defs.vh
// Purpose: Shared constants of the disk start and seek control block.
// Assumes: A 50 MHz system clock.
// Notes:   Counts follow from their times.
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH

// **********
// Clock and time bases
// **********
`define DSS_CLK_HZ        50000000
`define DSS_CLR_MS        60
`define DSS_CLR_CYCLES    (`DSS_CLK_HZ / 1000 * `DSS_CLR_MS + 1)
`define DSS_TICK_HZ       50
`define DSS_TICK_CYCLES   (`DSS_CLK_HZ / `DSS_TICK_HZ)
`define DSS_GUARD_CYCLES  12'hBB8

// **********
// Timing counter taps, in 50 Hz steps
// **********
`define DSS_TC_W          12
`define DSS_TAP8          12'h07D
`define DSS_TAP30         12'h5DC
`define DSS_TAP60         12'hBB8

// **********
// Seek distance
// **********
`define DSS_DEC_LIMIT     8'h20
`define DSS_DIST_ZERO     8'h00
`define DSS_LOW_MSB       4
`define DSS_EXTRA_BIT     5

`endif

// ### core/dss_diff_cnt.v
// Purpose: Seek difference counter, loaded and stepped down.
// Assumes: Load and step are same-clock logic; load wins.
// Notes:   The distance-equals-one flag is registered with the count.
`include "dss_defs.vh"
`default_nettype none

module dss_diff_cnt #(
	parameter W = 8
) (
	input  wire         i_clk,
	input  wire         i_rst_n,
	input  wire         i_load,
	input  wire [W-1:0] i_value,
	input  wire         i_dec,
	output reg  [W-1:0] o_count,
	output reg          o_one
);

	reg [W-1:0] cnt_d;

	// **********
	// Next count
	// **********
	// Load wins over a step arriving in the same cycle.
	always @* begin
		cnt_d = o_count;
		if (i_load) begin
			cnt_d = i_value;
		end else if (i_dec && (o_count != {W{1'b0}})) begin
			cnt_d = o_count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Count and its distance-equals-one flag.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= {W{1'b0}};
			o_one   <= 1'b0;
		end else begin
			o_count <= cnt_d;
			o_one   <= (cnt_d == {{(W-1){1'b0}}, 1'b1});
		end
	end

endmodule

`default_nettype wire

// ### core/dss_ctrl.v
// Purpose: Power-on, start, first seek, normal seek and write protection control.
// Assumes: All pins are asynchronous; the address is held around select.
// Notes:   Every output comes straight from a flip-flop.
//
// Contract
// - Write without erase over 60 us blocks.
// - Erase without write over 60 us blocks.
// - More than one head selected blocks.
// - Read with write or erase blocks.
// - Any enable while moving blocks.
// - Power clear over 60 ms, clears, sets prep.
// - Clear drives master clear, direction, loaded, seek.
// - Master clear: slow, edge select, count, decel.
// - Slow holds end-of-position reset, reduced speed.
// - Slow clears both head select bits.
// - No ready blocks start and fault set.
// - Button with ready sets start, removes clear.
// - Start releases counter, steps at 50 Hz.
// - Stage eight starts cleaning motor.
// - Thirty seconds done; parked stops motor.
// - Sixty tap fall ends cycle, starts first seek.
// - First seek zone exit, reverse, centre forward.
// - New versus old address sets direction.
// - Load difference, step down, flag one.
// - Select with seek command starts velocity seek.
// - Maximum deceleration below 32 remaining.
// - Last step ends count, toggles direction.
`include "dss_defs.vh"
`default_nettype none

module dss_ctrl #(
	parameter AW         = 8,
	parameter CLR_CYCLES = `DSS_CLR_CYCLES,
	parameter TICK_CYCLES = `DSS_TICK_CYCLES
) (
	input  wire          I_MCLK,
	input  wire          I_ARST_N,
	input  wire          I_START_BUTTON_PRESS,
	input  wire          I_READY_TO_OPERATE,
	input  wire          I_BRUSHES_PARKED,
	input  wire          I_OPTICAL_ZERO_ZONE,
	input  wire          I_EVEN_TRACK_AREA,
	input  wire          I_TRACK_CENTRE_ZERO,
	input  wire          I_TRACK_STEP_PULSE,
	input  wire          I_ON_CYLINDER_PREP,
	input  wire          I_WRITE_CURRENT,
	input  wire          I_ERASE_CURRENT,
	input  wire [3:0]    I_HEAD_ACTIVE,
	input  wire          I_READ_EN,
	input  wire          I_WRITE_EN,
	input  wire          I_ERASE_EN,
	input  wire          I_POSITIONER_MOVING,
	input  wire [AW-1:0] I_ADDR,
	input  wire          I_CONTROL_SELECT,
	input  wire          I_SEEK_COMMAND_LINE,
	input  wire          I_HEAD_SELECT_TAG,
	output reg           O_POWER_ON_CLEAR,
	output reg           O_MASTER_CLEAR,
	output reg           O_FAULT_LATCH,
	output reg           O_WRITE_BLOCK,
	output reg           O_START,
	output reg           O_PACK_MOTOR_ON,
	output reg           O_CARTRIDGE_EXCHANGE_PREP,
	output reg           O_CLEANING_MOTOR_ON,
	output reg           O_CLEANING_DONE,
	output reg           O_START_CYCLE_END,
	output reg           O_FIRST_SEEK_LATCH,
	output reg           O_FIRST_SEEK_FORWARD,
	output reg           O_PARK_POSITION_HOLD,
	output reg           O_CARTRIDGE_LOADED,
	output reg           O_NORMAL_SEEK,
	output reg           O_REVERSE_TO_ZERO_SEEK,
	output reg           O_FORWARD_DIRECTION,
	output reg           O_SLOW_MOTION,
	output reg           O_REDUCED_SPEED,
	output reg           O_POSITIVE_EDGE_SELECT,
	output reg  [1:0]    O_HEAD_SELECT,
	output reg           O_NORMAL_SEEK_PREP,
	output reg           O_COUNT_ENABLE,
	output reg           O_MAX_DECEL,
	output reg           O_END_OF_POSITION,
	output wire          O_DISTANCE_EQUALS_ONE,
	output reg  [4:0]    O_DISTANCE_LOW,
	output reg           O_DISTANCE_EXTRA
);

	localparam NS = 17 + 4 + AW;

	// **********
	// Functions
	// **********
	// Saturating increment of a guard timer, cleared when its condition drops.
	function [11:0] guard_next;
		input        cond;
		input [11:0] cnt;
		begin
			if (!cond) begin
				guard_next = 12'h000;
			end else if (cnt == `DSS_GUARD_CYCLES) begin
				guard_next = cnt;
			end else begin
				guard_next = cnt + 12'h001;
			end
		end
	endfunction

	// True when more than one bit of a head vector is set.
	function more_than_one;
		input [3:0] v;
		begin
			more_than_one = (v & (v - 4'h1)) != 4'h0;
		end
	endfunction

	// **********
	// Reset release and input synchronisers
	// **********
	reg          rst_s1_q;
	reg          rst_n_q;
	reg [NS-1:0] pin_s1_q;
	reg [NS-1:0] pin_q;

	// Reset is released through two flip-flops.
	always @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Every pin passes two flip-flops before any logic reads it.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= {NS{1'b0}};
			pin_q    <= {NS{1'b0}};
		end else begin
			pin_s1_q <= {I_START_BUTTON_PRESS, I_READY_TO_OPERATE, I_BRUSHES_PARKED,
				I_OPTICAL_ZERO_ZONE, I_EVEN_TRACK_AREA, I_TRACK_CENTRE_ZERO, I_TRACK_STEP_PULSE,
				I_ON_CYLINDER_PREP, I_WRITE_CURRENT, I_ERASE_CURRENT, I_READ_EN, I_WRITE_EN,
				I_ERASE_EN, I_POSITIONER_MOVING, I_CONTROL_SELECT, I_SEEK_COMMAND_LINE,
				I_HEAD_SELECT_TAG, I_HEAD_ACTIVE, I_ADDR};
			pin_q    <= pin_s1_q;
		end
	end

	wire          btn      = pin_q[NS-1];
	wire          ready_to_operate      = pin_q[NS-2];
	wire          parked   = pin_q[NS-3];
	wire          optical_zero_zone      = pin_q[NS-4];
	wire          ao       = pin_q[NS-5];
	wire          track_centre_zero      = pin_q[NS-6];
	wire          step     = pin_q[NS-7];
	wire          oncyl    = pin_q[NS-8];
	wire          wcur     = pin_q[NS-9];
	wire          ecur     = pin_q[NS-10];
	wire          rd_en    = pin_q[NS-11];
	wire          wr_en    = pin_q[NS-12];
	wire          er_en    = pin_q[NS-13];
	wire          moving   = pin_q[NS-14];
	wire          cts      = pin_q[NS-15];
	wire          seek_cmd = pin_q[NS-16];
	wire          hs_tag   = pin_q[NS-17];
	wire [3:0]    heads    = pin_q[AW+3:AW];
	wire [AW-1:0] addr     = pin_q[AW-1:0];

	// Edge memories of the synchronised pins.
	reg btn_prev_q;
	reg cts_prev_q;
	reg step_prev_q;
	reg hs_prev_q;

	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			btn_prev_q  <= 1'b0;
			cts_prev_q  <= 1'b0;
			step_prev_q <= 1'b0;
			hs_prev_q   <= 1'b0;
		end else begin
			btn_prev_q  <= btn;
			cts_prev_q  <= cts;
			step_prev_q <= step;
			hs_prev_q   <= hs_tag;
		end
	end

	wire btn_rise  = btn & ~btn_prev_q;
	wire cts_rise  = cts & ~cts_prev_q;
	wire step_rise = step & ~step_prev_q;
	wire hs_rise   = hs_tag & ~hs_prev_q;

	// **********
	// Power-on clear and master clear
	// **********
	reg [31:0] clr_cnt_q;

	// Power-on clear stays high for more than 60 ms after reset release.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			clr_cnt_q        <= 32'h00000000;
			O_POWER_ON_CLEAR <= 1'b1;
		end else if (O_POWER_ON_CLEAR) begin
			clr_cnt_q        <= clr_cnt_q + 32'h00000001;
			O_POWER_ON_CLEAR <= (clr_cnt_q < CLR_CYCLES - 1);
		end
	end

	wire mc = O_MASTER_CLEAR;

	// Master clear follows power clear, lack of start, or a fault.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_MASTER_CLEAR <= 1'b1;
		end else begin
			O_MASTER_CLEAR <= O_POWER_ON_CLEAR | ~O_START | O_FAULT_LATCH;
		end
	end

	// **********
	// Write protection
	// **********
	reg [11:0] wonly_q;
	reg [11:0] eonly_q;

	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wonly_q <= 12'h000;
			eonly_q <= 12'h000;
		end else begin
			wonly_q <= guard_next(wcur & ~ecur, wonly_q);
			eonly_q <= guard_next(ecur & ~wcur, eonly_q);
		end
	end

	// Over 60 us means the condition still holds once the timer is full.
	wire w_over  = (wonly_q == `DSS_GUARD_CYCLES) & wcur & ~ecur;
	wire e_over  = (eonly_q == `DSS_GUARD_CYCLES) & ecur & ~wcur;
	wire multi   = more_than_one(heads);
	wire rd_clash = rd_en & (wr_en | er_en);
	wire mv_clash = (rd_en | wr_en | er_en) & moving;
	wire unsafe  = w_over | e_over | multi | rd_clash | mv_clash;

	// Fault latch holds a check; writes are blocked while either stands.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_FAULT_LATCH <= 1'b0;
			O_WRITE_BLOCK <= 1'b1;
		end else begin
			if (O_POWER_ON_CLEAR) begin
				O_FAULT_LATCH <= 1'b0;
			end else if (unsafe & ready_to_operate) begin
				O_FAULT_LATCH <= 1'b1;
			end
			O_WRITE_BLOCK <= unsafe | O_FAULT_LATCH;
		end
	end

	// **********
	// Start flags and timing counter
	// **********
	reg [31:0]          div_q;
	reg                 tick_q;
	reg [`DSS_TC_W-1:0] tc_q;
	reg                 sixty_prev_q;

	// Start needs ready; power clear resets start and pack motor.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_START                   <= 1'b0;
			O_PACK_MOTOR_ON           <= 1'b0;
			O_CARTRIDGE_EXCHANGE_PREP <= 1'b0;
		end else if (O_POWER_ON_CLEAR) begin
			O_START                   <= 1'b0;
			O_PACK_MOTOR_ON           <= 1'b0;
			O_CARTRIDGE_EXCHANGE_PREP <= 1'b1;
		end else begin
			if (btn_rise & ready_to_operate) begin
				O_START         <= 1'b1;
				O_PACK_MOTOR_ON <= 1'b1;
			end
			if (O_START_CYCLE_END) begin
				O_CARTRIDGE_EXCHANGE_PREP <= 1'b0;
			end
		end
	end

	// The 50 Hz step enable.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (div_q >= TICK_CYCLES - 1) begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	// Counter held clear until start, then stepped up to the sixty-second tap.
	wire tc_clear  = ~O_START;
	wire tap8      = (tc_q >= `DSS_TAP8);
	wire tap30     = (tc_q >= `DSS_TAP30);
	wire sixty_tap = ~tc_clear & (tc_q < `DSS_TAP60);

	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tc_q         <= {`DSS_TC_W{1'b0}};
			sixty_prev_q <= 1'b0;
		end else begin
			if (tc_clear) begin
				tc_q <= {`DSS_TC_W{1'b0}};
			end else if (tick_q && (tc_q != `DSS_TAP60)) begin
				tc_q <= tc_q + {{(`DSS_TC_W-1){1'b0}}, 1'b1};
			end
			sixty_prev_q <= sixty_tap;
		end
	end

	// Cleaning motor and the end of the start cycle.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_CLEANING_MOTOR_ON <= 1'b0;
			O_CLEANING_DONE     <= 1'b0;
			O_START_CYCLE_END   <= 1'b0;
		end else if (tc_clear) begin
			O_CLEANING_MOTOR_ON <= 1'b0;
			O_CLEANING_DONE     <= 1'b0;
			O_START_CYCLE_END   <= 1'b0;
		end else begin
			if (O_CLEANING_DONE & parked) begin
				O_CLEANING_MOTOR_ON <= 1'b0;
			end else if (tap8 & ~O_CLEANING_DONE) begin
				O_CLEANING_MOTOR_ON <= 1'b1;
			end
			if (tap30) begin
				O_CLEANING_DONE <= 1'b1;
			end
			O_START_CYCLE_END <= sixty_prev_q & ~sixty_tap;
		end
	end

	// **********
	// First seek
	// **********
	reg saw_zero_q;

	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_FIRST_SEEK_LATCH   <= 1'b0;
			O_FIRST_SEEK_FORWARD <= 1'b0;
			O_PARK_POSITION_HOLD <= 1'b1;
			O_CARTRIDGE_LOADED   <= 1'b0;
			O_NORMAL_SEEK        <= 1'b0;
			saw_zero_q           <= 1'b0;
		end else if (mc) begin
			O_FIRST_SEEK_LATCH   <= 1'b0;
			O_FIRST_SEEK_FORWARD <= 1'b0;
			O_PARK_POSITION_HOLD <= 1'b1;
			O_CARTRIDGE_LOADED   <= 1'b0;
			O_NORMAL_SEEK        <= 1'b0;
			saw_zero_q           <= 1'b0;
		end else begin
			if (O_START_CYCLE_END & O_CARTRIDGE_EXCHANGE_PREP) begin
				O_FIRST_SEEK_LATCH   <= 1'b1;
				O_FIRST_SEEK_FORWARD <= 1'b1;
				O_PARK_POSITION_HOLD <= 1'b0;
				O_CARTRIDGE_LOADED   <= 1'b1;
			end
			if (O_FIRST_SEEK_LATCH & optical_zero_zone) begin
				saw_zero_q <= 1'b1;
			end
			if (~O_CARTRIDGE_LOADED) begin
				O_NORMAL_SEEK <= 1'b0;
			end else if (O_FIRST_SEEK_LATCH & saw_zero_q & ~ao & ~optical_zero_zone) begin
				O_NORMAL_SEEK        <= 1'b1;
				O_FIRST_SEEK_FORWARD <= 1'b0;
			end
		end
	end

	// Reverse-to-zero seek follows normal seek with slow motion.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_REVERSE_TO_ZERO_SEEK <= 1'b0;
		end else begin
			O_REVERSE_TO_ZERO_SEEK <= O_NORMAL_SEEK & O_SLOW_MOTION & ~mc;
		end
	end

	// **********
	// Normal seek
	// **********
	reg  [AW-1:0] old_q;
	reg           rzs_prev_q;
	wire          seek_go = cts_rise & seek_cmd & O_NORMAL_SEEK & ~mc;
	wire          fwd_new = (addr > old_q);
	wire [AW-1:0] mag     = fwd_new ? (addr - old_q) : (old_q - addr);
	wire [AW-1:0] cnt;
	wire          last    = step_rise & O_COUNT_ENABLE & O_DISTANCE_EQUALS_ONE;

	dss_diff_cnt #(
		.W (AW)
	) u_cnt (
		.i_clk   (I_MCLK),
		.i_rst_n (rst_n_q),
		.i_load  (seek_go),
		.i_value (mag),
		.i_dec   (step_rise & O_COUNT_ENABLE),
		.o_count (cnt),
		.o_one   (O_DISTANCE_EQUALS_ONE)
	);

	// Old address, count enable and direction.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			old_q               <= {AW{1'b0}};
			O_COUNT_ENABLE      <= 1'b0;
			O_FORWARD_DIRECTION <= 1'b0;
			O_NORMAL_SEEK_PREP  <= 1'b0;
			rzs_prev_q          <= 1'b0;
		end else if (mc) begin
			old_q               <= {AW{1'b0}};
			O_COUNT_ENABLE      <= 1'b0;
			O_FORWARD_DIRECTION <= 1'b0;
			O_NORMAL_SEEK_PREP  <= 1'b0;
			rzs_prev_q          <= 1'b0;
		end else begin
			rzs_prev_q         <= O_REVERSE_TO_ZERO_SEEK;
			O_NORMAL_SEEK_PREP <= cts & seek_cmd;
			if (seek_go) begin
				old_q               <= addr;
				O_FORWARD_DIRECTION <= fwd_new;
				O_COUNT_ENABLE      <= (mag != `DSS_DIST_ZERO);
			end else if (last) begin
				O_COUNT_ENABLE      <= 1'b0;
				O_FORWARD_DIRECTION <= ~O_FORWARD_DIRECTION;
			end else if (O_FIRST_SEEK_FORWARD & ~O_NORMAL_SEEK) begin
				O_FORWARD_DIRECTION <= 1'b1;
			end else if (O_REVERSE_TO_ZERO_SEEK & ~rzs_prev_q) begin
				O_FORWARD_DIRECTION <= 1'b0;
			end else if (O_REVERSE_TO_ZERO_SEEK & track_centre_zero) begin
				O_FORWARD_DIRECTION <= 1'b1;
			end
		end
	end

	// Deceleration drive and the speed profile bits.
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_MAX_DECEL      <= 1'b0;
			O_DISTANCE_LOW   <= 5'h00;
			O_DISTANCE_EXTRA <= 1'b0;
		end else begin
			O_MAX_DECEL      <= ~mc & O_COUNT_ENABLE & ~last & (cnt < `DSS_DEC_LIMIT);
			O_DISTANCE_LOW   <= cnt[`DSS_LOW_MSB:0];
			O_DISTANCE_EXTRA <= cnt[`DSS_EXTRA_BIT];
		end
	end

	// **********
	// Slow motion, end of position and head selection
	// **********
	always @(posedge I_MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_SLOW_MOTION          <= 1'b1;
			O_REDUCED_SPEED        <= 1'b1;
			O_END_OF_POSITION      <= 1'b0;
			O_POSITIVE_EDGE_SELECT <= 1'b1;
			O_HEAD_SELECT          <= 2'h0;
		end else begin
			if (mc) begin
				O_SLOW_MOTION <= 1'b1;
			end else if (oncyl) begin
				O_SLOW_MOTION <= 1'b0;
			end
			O_REDUCED_SPEED <= O_SLOW_MOTION | mc;
			if (O_SLOW_MOTION | mc | seek_go) begin
				O_END_OF_POSITION <= 1'b0;
			end else if (last) begin
				O_END_OF_POSITION <= 1'b1;
			end
			if (mc) begin
				O_POSITIVE_EDGE_SELECT <= 1'b1;
			end else if (seek_go) begin
				O_POSITIVE_EDGE_SELECT <= ~addr[0];
			end
			if (O_SLOW_MOTION) begin
				O_HEAD_SELECT <= 2'h0;
			end else if (hs_rise) begin
				O_HEAD_SELECT <= addr[1:0];
			end
		end
	end

endmodule

`default_nettype wire

// ### tb/dss_ctrl_props.sv
// Purpose: Port checks of the start and seek control block.
// Assumes: One clock domain; the reset pin low disables every check.
// Notes:   Bound to every instance of the control block.
`default_nettype none
module dss_ctrl_chk #(
	parameter int CLR_CYCLES = 50
) (
	input wire logic       I_MCLK,
	input wire logic       I_ARST_N,
	input wire logic       I_READY_TO_OPERATE,
	input wire logic       I_WRITE_CURRENT,
	input wire logic       I_ERASE_CURRENT,
	input wire logic       I_READ_EN,
	input wire logic       I_WRITE_EN,
	input wire logic       I_ERASE_EN,
	input wire logic       O_POWER_ON_CLEAR,
	input wire logic       O_MASTER_CLEAR,
	input wire logic       O_FAULT_LATCH,
	input wire logic       O_WRITE_BLOCK,
	input wire logic       O_START,
	input wire logic       O_PACK_MOTOR_ON,
	input wire logic       O_CARTRIDGE_EXCHANGE_PREP,
	input wire logic       O_FIRST_SEEK_LATCH,
	input wire logic       O_FIRST_SEEK_FORWARD,
	input wire logic       O_PARK_POSITION_HOLD,
	input wire logic       O_CARTRIDGE_LOADED,
	input wire logic       O_NORMAL_SEEK,
	input wire logic       O_FORWARD_DIRECTION,
	input wire logic       O_SLOW_MOTION,
	input wire logic       O_REDUCED_SPEED,
	input wire logic       O_POSITIVE_EDGE_SELECT,
	input wire logic [1:0] O_HEAD_SELECT,
	input wire logic       O_COUNT_ENABLE,
	input wire logic       O_MAX_DECEL,
	input wire logic       O_END_OF_POSITION,
	input wire logic       O_START_CYCLE_END,
	input wire logic       O_DISTANCE_EXTRA
);
	timeunit 1ns;
	timeprecision 1ps;
	int pc_cnt;
	int gd_cnt;
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_ARST_N);
	// Count power clear cycles and cycles of lone write or erase current.
	always @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			pc_cnt <= 0;
			gd_cnt <= 0;
		end else begin
			pc_cnt <= O_POWER_ON_CLEAR ? pc_cnt + 1 : pc_cnt;
			gd_cnt <= (I_WRITE_CURRENT ^ I_ERASE_CURRENT) ? gd_cnt + 1 : 0;
		end
	end
	// **********
	// Properties
	// **********
	sequence mc_run;
		O_MASTER_CLEAR [*3];
	endsequence
	sequence fs_go;
		O_FIRST_SEEK_LATCH && O_FIRST_SEEK_FORWARD && !O_PARK_POSITION_HOLD && !O_CARTRIDGE_EXCHANGE_PREP
			##1 O_FORWARD_DIRECTION;
	endsequence
	a_power_clear: assert property ($fell(O_POWER_ON_CLEAR) |-> pc_cnt >= CLR_CYCLES &&
		O_CARTRIDGE_EXCHANGE_PREP && !O_START && !O_FAULT_LATCH && !O_PACK_MOTOR_ON)
		else $error("power clear too short or flags wrong");
	a_clear_effects: assert property (mc_run |-> !O_COUNT_ENABLE && !O_MAX_DECEL &&
		O_POSITIVE_EDGE_SELECT && O_SLOW_MOTION && !O_FORWARD_DIRECTION && !O_CARTRIDGE_LOADED && !O_NORMAL_SEEK)
		else $error("master clear left a flag set");
	a_slow_hold: assert property (O_SLOW_MOTION && $past(O_SLOW_MOTION) |->
		!O_END_OF_POSITION && O_REDUCED_SPEED && O_HEAD_SELECT == 2'h0)
		else $error("slow motion outputs wrong");
	a_start_ready: assert property ($rose(O_START) |-> $past(I_READY_TO_OPERATE, 3))
		else $error("start set without ready");
	a_start_clear: assert property ($rose(O_START) |=> $fell(O_MASTER_CLEAR))
		else $error("master clear not removed");
	a_cycle_end: assert property ($rose(O_START_CYCLE_END) |=> fs_go)
		else $error("first seek not started");
	a_decel_near: assert property (O_MAX_DECEL |-> !O_DISTANCE_EXTRA)
		else $error("deceleration with far distance");
	a_last_step: assert property ($fell(O_COUNT_ENABLE) && !O_MASTER_CLEAR |->
		!O_MAX_DECEL && O_FORWARD_DIRECTION != $past(O_FORWARD_DIRECTION))
		else $error("last step handling wrong");
	a_read_mix: assert property ((I_READ_EN && (I_WRITE_EN || I_ERASE_EN)) [*4] |=> O_WRITE_BLOCK)
		else $error("read with write not blocked");
	a_lone_current: assert property (gd_cnt == 3010 |-> O_WRITE_BLOCK)
		else $error("lone current not blocked");
endmodule

bind dss_ctrl dss_ctrl_chk #(.CLR_CYCLES(CLR_CYCLES)) i_chk (.*);
`default_nettype wire

// ### tb/dss_cu_model.sv
// Purpose: Control unit model that issues seek commands and head select tags.
// Assumes: The bus is held three cycles on each side of a tag.
// Notes:   A released bus shows the inverse of its last value.
`default_nettype none
module dss_cu_model (
	input  wire logic       i_clk,
	input  wire logic       i_go,
	input  wire logic [7:0] i_addr,
	input  wire logic       i_tag,
	output var  logic [7:0] o_addr,
	output var  logic       o_cts,
	output var  logic       o_seek,
	output var  logic       o_tag,
	output var  logic       o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int   ph;
	logic kind;
	// Start idle with every line low.
	initial begin
		{o_addr, o_cts, o_seek, o_tag, o_busy, kind} = 13'h0000;
		ph = 0;
	end
	// Tag high in phases 3 to 6; bus released after phase 9.
	always @(posedge i_clk) begin
		if (!o_busy && i_go) begin
			o_busy <= 1'h1;
			o_addr <= i_addr;
			kind   <= i_tag;
			ph     <= 0;
		end else if (o_busy) begin
			ph     <= ph + 1;
			o_cts  <= !kind && ph >= 2 && ph < 6;
			o_seek <= !kind && ph >= 2 && ph < 6;
			o_tag  <= kind && ph >= 2 && ph < 6;
			if (ph == 9) begin
				o_busy <= 1'h0;
				o_addr <= ~o_addr;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the start and seek control block.
// Assumes: Short counts; a control unit model drives the bus.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", n, e, a); end end
`define WAITV(s, v, lim) begin k = 0; while ((s) !== (v) && k < (lim)) begin @(posedge I_MCLK); k++; end if ((s) !== (v)) begin n_fail++; $display("BAD wait exp %0h got %0h", v, s); end_of_test(); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       I_MCLK, I_ARST_N, I_START_BUTTON_PRESS, I_READY_TO_OPERATE, I_BRUSHES_PARKED;
	logic       I_OPTICAL_ZERO_ZONE, I_EVEN_TRACK_AREA, I_TRACK_CENTRE_ZERO, I_TRACK_STEP_PULSE;
	logic       I_ON_CYLINDER_PREP, I_WRITE_CURRENT, I_ERASE_CURRENT, I_READ_EN, I_WRITE_EN, I_ERASE_EN;
	logic       I_POSITIONER_MOVING, I_CONTROL_SELECT, I_SEEK_COMMAND_LINE, I_HEAD_SELECT_TAG;
	logic [3:0] I_HEAD_ACTIVE;
	logic [7:0] I_ADDR, cu_a;
	logic       O_POWER_ON_CLEAR, O_MASTER_CLEAR, O_FAULT_LATCH, O_WRITE_BLOCK, O_START, O_PACK_MOTOR_ON;
	logic       O_CARTRIDGE_EXCHANGE_PREP, O_CLEANING_MOTOR_ON, O_CLEANING_DONE, O_START_CYCLE_END;
	logic       O_FIRST_SEEK_LATCH, O_FIRST_SEEK_FORWARD, O_PARK_POSITION_HOLD, O_CARTRIDGE_LOADED;
	logic       O_NORMAL_SEEK, O_REVERSE_TO_ZERO_SEEK, O_FORWARD_DIRECTION, O_SLOW_MOTION, O_REDUCED_SPEED;
	logic       O_POSITIVE_EDGE_SELECT, O_NORMAL_SEEK_PREP, O_COUNT_ENABLE, O_MAX_DECEL, O_END_OF_POSITION;
	logic       O_DISTANCE_EQUALS_ONE, O_DISTANCE_EXTRA, cu_go, cu_tag, cu_busy;
	logic [1:0] O_HEAD_SELECT;
	logic [4:0] O_DISTANCE_LOW;
	int         n_fail, comparisons, k;
	// Short counts shorten the start cycle.
	dss_ctrl #(.CLR_CYCLES(50), .TICK_CYCLES(4)) i_dut (.*);
	dss_cu_model i_cu (.i_clk(I_MCLK), .i_go(cu_go), .i_addr(cu_a), .i_tag(cu_tag), .o_addr(I_ADDR),
		.o_cts(I_CONTROL_SELECT), .o_seek(I_SEEK_COMMAND_LINE), .o_tag(I_HEAD_SELECT_TAG), .o_busy(cu_busy));
	// Clock of 50 MHz.
	always #10 I_MCLK = ~I_MCLK;
	// **********
	// Tasks
	// **********
	task automatic end_of_test();
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge I_MCLK);
	endtask
	task automatic press();
		I_START_BUTTON_PRESS <= 1'h1;
		cyc(6);
		I_START_BUTTON_PRESS <= 1'h0;
		cyc(6);
	endtask
	task automatic cu(input logic t, input logic [7:0] a);
		cu_go  <= 1'h1;
		cu_tag <= t;
		cu_a   <= a;
		cyc(1);
		cu_go <= 1'h0;
		cyc(1);
		`WAITV(cu_busy, 1'h0, 30)
		cyc(3);
	endtask
	task automatic steps(input int n);
		repeat (n) begin
			I_TRACK_STEP_PULSE <= 1'h1;
			cyc(3);
			I_TRACK_STEP_PULSE <= 1'h0;
			cyc(3);
		end
		cyc(3);
	endtask
	// **********
	// Main sequence
	// **********
	initial begin
		{I_MCLK, I_ARST_N, I_START_BUTTON_PRESS, I_READY_TO_OPERATE, I_BRUSHES_PARKED} = 5'h00;
		{I_OPTICAL_ZERO_ZONE, I_EVEN_TRACK_AREA, I_TRACK_CENTRE_ZERO, I_TRACK_STEP_PULSE} = 4'h0;
		{I_ON_CYLINDER_PREP, I_WRITE_CURRENT, I_ERASE_CURRENT, I_READ_EN, I_WRITE_EN, I_ERASE_EN} = 6'h00;
		{I_POSITIONER_MOVING, I_HEAD_ACTIVE, cu_go, cu_tag, cu_a} = 15'h0000;
		n_fail = 0;
		comparisons = 0;
		cyc(6);
		I_ARST_N <= 1'h1;
		cyc(2);
		`CHK("clear flags", 5'h1F, {O_POWER_ON_CLEAR, O_MASTER_CLEAR, O_SLOW_MOTION, O_REDUCED_SPEED, O_POSITIVE_EDGE_SELECT})
		`CHK("cleared", 7'h00, {O_NORMAL_SEEK_PREP, O_FORWARD_DIRECTION, O_CARTRIDGE_LOADED, O_NORMAL_SEEK, O_COUNT_ENABLE, O_MAX_DECEL, O_END_OF_POSITION})
		`WAITV(O_POWER_ON_CLEAR, 1'h0, 100)
		`CHK("clear length", 1'h1, k >= 48)
		`CHK("clear state", 4'h8, {O_CARTRIDGE_EXCHANGE_PREP, O_START, O_FAULT_LATCH, O_PACK_MOTOR_ON})
		press();
		`CHK("no ready", 2'h0, {O_START, O_FAULT_LATCH})
		I_READY_TO_OPERATE <= 1'h1;
		press();
		`CHK("start", 3'h6, {O_START, O_PACK_MOTOR_ON, O_MASTER_CLEAR})
		`WAITV(O_CLEANING_MOTOR_ON, 1'h1, 600)
		`CHK("stage eight", 1'h1, k > 480 && k < 505)
		cu(1'h1, 8'h03);
		`CHK("head slow", 2'h0, O_HEAD_SELECT)
		`WAITV(O_CLEANING_DONE, 1'h1, 6000)
		`CHK("thirty", 1'h1, k > 5460 && k < 5510)
		`CHK("motor held", 1'h1, O_CLEANING_MOTOR_ON)
		I_BRUSHES_PARKED <= 1'h1;
		cyc(4);
		`CHK("motor off", 1'h0, O_CLEANING_MOTOR_ON)
		`WAITV(O_START_CYCLE_END, 1'h1, 6100)
		cyc(3);
		`CHK("first seek", 6'h33, {O_FIRST_SEEK_LATCH, O_FIRST_SEEK_FORWARD, O_CARTRIDGE_EXCHANGE_PREP, O_PARK_POSITION_HOLD, O_CARTRIDGE_LOADED, O_FORWARD_DIRECTION})
		I_OPTICAL_ZERO_ZONE <= 1'h1;
		I_EVEN_TRACK_AREA <= 1'h1;
		cyc(5);
		I_OPTICAL_ZERO_ZONE <= 1'h0;
		I_EVEN_TRACK_AREA <= 1'h0;
		`WAITV(O_NORMAL_SEEK, 1'h1, 20)
		cyc(4);
		`CHK("reverse", 2'h2, {O_REVERSE_TO_ZERO_SEEK, O_FORWARD_DIRECTION})
		I_TRACK_CENTRE_ZERO <= 1'h1;
		cyc(5);
		`CHK("centre", 1'h1, O_FORWARD_DIRECTION)
		{I_TRACK_CENTRE_ZERO, I_ON_CYLINDER_PREP} <= 2'h1;
		cyc(5);
		I_ON_CYLINDER_PREP <= 1'h0;
		cu(1'h1, 8'h03);
		`CHK("head", 3'h6, {O_HEAD_SELECT, O_SLOW_MOTION})
		cu(1'h0, 8'h28);
		`CHK("seek out", 11'h668, {O_FORWARD_DIRECTION, O_COUNT_ENABLE, O_MAX_DECEL, O_END_OF_POSITION, O_POSITIVE_EDGE_SELECT, O_DISTANCE_EXTRA, O_DISTANCE_LOW})
		steps(8);
		`CHK("at 32", 7'h20, {O_MAX_DECEL, O_DISTANCE_EXTRA, O_DISTANCE_LOW})
		steps(1);
		`CHK("at 31", 7'h5F, {O_MAX_DECEL, O_DISTANCE_EXTRA, O_DISTANCE_LOW})
		steps(30);
		`CHK("one left", 2'h3, {O_DISTANCE_EQUALS_ONE, O_COUNT_ENABLE})
		steps(1);
		`CHK("arrived", 5'h02, {O_COUNT_ENABLE, O_FORWARD_DIRECTION, O_MAX_DECEL, O_END_OF_POSITION, O_DISTANCE_EQUALS_ONE})
		cu(1'h0, 8'h26);
		`CHK("seek in", 8'h62, {O_FORWARD_DIRECTION, O_COUNT_ENABLE, O_MAX_DECEL, O_DISTANCE_LOW})
		steps(2);
		`CHK("back", 2'h1, {O_COUNT_ENABLE, O_FORWARD_DIRECTION})
		cu(1'h0, 8'h26);
		`CHK("same track", 1'h0, O_COUNT_ENABLE)
		// Each protection check starts from a fresh power clear.
		for (int c = 0; c < 5; c++) begin
			I_ARST_N <= 1'h0;
			cyc(6);
			I_ARST_N <= 1'h1;
			`WAITV(O_POWER_ON_CLEAR, 1'h0, 100)
			cyc(2);
			`CHK("idle", 1'h0, O_WRITE_BLOCK)
			case (c)
				0: I_WRITE_CURRENT <= 1'h1;
				1: I_ERASE_CURRENT <= 1'h1;
				2: I_HEAD_ACTIVE <= 4'h5;
				3: {I_READ_EN, I_WRITE_EN} <= 2'h3;
				default: {I_ERASE_EN, I_POSITIONER_MOVING} <= 2'h3;
			endcase
			`WAITV(O_WRITE_BLOCK, 1'h1, 3100)
			`CHK("block time", 1'h1, c < 2 ? (k > 2995 && k < 3012) : k < 8)
			cyc(20);
			{I_WRITE_CURRENT, I_ERASE_CURRENT, I_READ_EN, I_WRITE_EN, I_ERASE_EN, I_POSITIONER_MOVING} <= 6'h00;
			I_HEAD_ACTIVE <= 4'h0;
		end
		end_of_test();
	end
endmodule
`default_nettype wire
